// ===== src/frm_pkg.sv
// Summary of operation
// RULE1: host adds 32-bit offset pointer and 8-bit local address for register.
// RULE2: register address FFh means direct commands, no address phase.
// RULE3: host drops upper address bits beyond the device's register width.
// RULE4: table holds separate volatile and non-volatile 32-bit offset pointers.
// RULE5: local address goes into lowest byte or byte 1 of address.
// RULE6: each mapped bit says which local-address placement applies.
// RULE7: each bit gives write command, read command, bit position, address.
// RULE8: host reads, alters intended bits, writes back; atomic RMW allowed.
// RULE9: mapped bit locations are those valid right after power-up.
// RULE10: header word one 31:24 holds one-based table length in words.
// RULE11: header word one 23:16 holds major revision, value one.
// RULE12: header word one 15:8 holds minor revision, value one.
// RULE13: header word one 7:0 holds table identifier low byte 87h.
// RULE14: header word two 31:24 holds table identifier high byte FFh.
// RULE15: header word two 23:0 holds word-aligned table start byte address.
// RULE16: table word one holds volatile register block base pointer.
// RULE17: table word two holds non-volatile register block base pointer.
// RULE18: table word three 29:28 gives register command address width.
// RULE19: host computes 32-bit address then truncates to advertised width.
package frm_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0]  HDR_ONE_OFS   = 8'h00;
  localparam logic [7:0]  HDR_TWO_OFS   = 8'h04;
  localparam logic [7:0]  VOL_BASE_OFS  = 8'h08;
  localparam logic [7:0]  NVOL_BASE_OFS = 8'h0C;
  localparam logic [7:0]  CMD_WORD_OFS  = 8'h10;
  localparam logic [7:0]  CALC_CTRL_OFS = 8'h14;
  localparam logic [7:0]  CALC_ADDR_OFS = 8'h18;

  // ---------------------------------------------------------------
  // field values and positions
  // ---------------------------------------------------------------
  localparam logic [7:0]  TABLE_LEN     = 8'h03;
  localparam logic [7:0]  MAJOR_REV     = 8'h01;
  localparam logic [7:0]  MINOR_REV     = 8'h01;
  localparam logic [7:0]  ID_LSB        = 8'h87;
  localparam logic [7:0]  ID_MSB        = 8'hFF;
  localparam logic [7:0]  DIRECT_ADDR   = 8'hFF;
  localparam int          AW_POS        = 28;
  localparam logic [23:0] TABLE_PTR_DEF = 24'h000100;
  localparam logic [31:0] VOL_BASE_DEF  = 32'h00800000;
  localparam logic [31:0] NVOL_BASE_DEF = 32'h00000000;
  localparam logic [31:0] CMD_WORD_DEF  = 32'hC0000000;
  localparam logic [31:0] CALC_CTRL_RST = 32'h00000000;

  // htrans code and register-address calculator request and response
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic       nvol_sel;   // pick non-volatile base
    logic       byte1_sel;  // place local address in byte 1
    logic [7:0] local_addr; // local address within block
  } frm_calc_req_t;

  typedef struct packed {
    logic [31:0] addr;      // truncated physical address
    logic        direct;    // direct command, no address phase
  } frm_calc_rsp_t;

endpackage : frm_pkg

// ===== src/frm_addr_calc.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// physical register address former
// ---------------------------------------------------------------
module frm_addr_calc (
  input  wire logic                   clock,   // system clock
  input  wire logic                   sys_rst, // async reset, high
  input  wire frm_pkg::frm_calc_req_t req,     // calculation request
  input  wire logic [31:0]            vol,     // volatile base
  input  wire logic [31:0]            nvol,    // non-volatile base
  input  wire logic [1:0]             width,   // address byte code
  output      frm_pkg::frm_calc_rsp_t rsp      // registered result
);

  logic [31:0] base;
  logic [31:0] sum;
  logic [31:0] mask;

  // choose block base and add local address in chosen byte
  always_comb begin
    base = req.nvol_sel ? nvol : vol;                            // RULE4
    sum  = req.byte1_sel ? base + {16'h0000, req.local_addr, 8'h00}
                         : base + {24'h000000, req.local_addr};  // RULE5
    mask = 32'hFFFFFFFF >> (5'(24) - {width, 3'h0});             // RULE18
  end

  // register the truncated sum
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rsp <= '0;
    end else begin
      rsp.addr   <= sum & mask;                                  // RULE1
      rsp.direct <= (req.local_addr == frm_pkg::DIRECT_ADDR);    // RULE2
    end
  end

endmodule : frm_addr_calc

// ===== src/frm_table.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// register map parameter table, read over ahb-lite
// ---------------------------------------------------------------
module frm_table (
  input  wire logic        clock,     // 10 MHz system clock
  input  wire logic        sys_rst,   // async reset, high
  input  wire logic        hsel,      // slave select
  input  wire logic [31:0] haddr,     // byte address
  input  wire logic [1:0]  htrans,    // transfer type
  input  wire logic        hwrite,    // write when high
  input  wire logic [2:0]  hsize,     // transfer size
  input  wire logic        hready,    // bus ready in
  input  wire logic [31:0] hwdata,    // write data
  output      logic [31:0] hrdata,    // read data
  output      logic        hreadyout, // always ready
  output      logic        hresp      // always okay
);

  // ---------------------------------------------------------------
  // address phase capture
  // ---------------------------------------------------------------
  logic        dp_write;
  logic [7:0]  dp_addr;
  logic        take;
  frm_pkg::frm_calc_req_t calc_req;
  frm_pkg::frm_calc_rsp_t calc_rsp;
  logic [31:0] next_rdata;

  assign take = hsel && hready && (htrans == frm_pkg::HTRANS_NONSEQ);

  // latch write intent for data phase
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end else begin
      dp_write <= take && hwrite && (hsize == 3'h2)
                  && (haddr[31:8] == 24'h000000);
      dp_addr  <= haddr[7:0];
    end
  end

  // ---------------------------------------------------------------
  // calculator control register, software written
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      calc_req <= frm_pkg::frm_calc_req_t'(frm_pkg::CALC_CTRL_RST[9:0]);
    end else if (dp_write && dp_addr == frm_pkg::CALC_CTRL_OFS) begin
      calc_req <= frm_pkg::frm_calc_req_t'(hwdata[9:0]);          // RULE6
    end
  end

  frm_addr_calc u_calc (
    .clock   (clock),
    .sys_rst (sys_rst),
    .req     (calc_req),
    .vol     (frm_pkg::VOL_BASE_DEF),
    .nvol    (frm_pkg::NVOL_BASE_DEF),
    .width   (frm_pkg::CMD_WORD_DEF[frm_pkg::AW_POS +: 2]),
    .rsp     (calc_rsp)
  );

  // ---------------------------------------------------------------
  // read mux; table words fixed after power-up, calculator words follow writes
  // ---------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h00000000;
    unique case (haddr[7:0])
      frm_pkg::HDR_ONE_OFS:   next_rdata = {frm_pkg::TABLE_LEN,  // RULE10
                                            frm_pkg::MAJOR_REV,  // RULE11
                                            frm_pkg::MINOR_REV,  // RULE12
                                            frm_pkg::ID_LSB};    // RULE13
      frm_pkg::HDR_TWO_OFS:   next_rdata = {frm_pkg::ID_MSB,     // RULE14
                                            frm_pkg::TABLE_PTR_DEF
                                              & 24'hFFFFFC};     // RULE15
      frm_pkg::VOL_BASE_OFS:  next_rdata = frm_pkg::VOL_BASE_DEF;  // RULE16
      frm_pkg::NVOL_BASE_OFS: next_rdata = frm_pkg::NVOL_BASE_DEF; // RULE17
      frm_pkg::CMD_WORD_OFS:  next_rdata = frm_pkg::CMD_WORD_DEF;  // RULE18
      frm_pkg::CALC_CTRL_OFS: next_rdata = {21'h000000,          // RULE7
                                            calc_rsp.direct,     // RULE2
                                            calc_req};
      frm_pkg::CALC_ADDR_OFS: next_rdata = calc_rsp.addr;        // RULE19
      default:                next_rdata = 32'h00000000;
    endcase
    if (haddr[31:8] != 24'h000000) begin
      next_rdata = 32'h00000000;
    end
  end

  // register read data for the data phase; table fixed (RULE9)
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
      hrdata <= next_rdata;                                      // RULE9
    end
  end

  // zero wait state, okay response
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule : frm_table

// ===== sim/frm_table_sva.sv
`timescale 1ns/10ps
module frm_table_chk (
  input wire logic        clock,     // clock
  input wire logic        sys_rst,   // reset
  input wire logic        hsel,      // select
  input wire logic [31:0] haddr,     // address
  input wire logic [1:0]  htrans,    // type
  input wire logic        hwrite,    // write
  input wire logic        hready,    // ready in
  input wire logic [31:0] hrdata,    // read data
  input wire logic        hreadyout, // ready out
  input wire logic        hresp      // response
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // read taken at this edge
  logic rd;
  assign rd = hsel && hready && htrans == 2'h2 && !hwrite;
  hdr_one_a: assert property (rd && haddr == 32'h0
    |=> hrdata == 32'h03010187) else $error("header one wrong");
  hdr_two_a: assert property (rd && haddr == 32'h4
    |=> hrdata[31:24] == 8'hFF && hrdata[1:0] == 2'h0) else $error("hdr2");
  vol_base_a: assert property (rd && haddr == 32'h8
    |=> hrdata == frm_pkg::VOL_BASE_DEF) else $error("volatile base");
  nvol_base_a: assert property (rd && haddr == 32'hC
    |=> hrdata == frm_pkg::NVOL_BASE_DEF) else $error("nonvolatile base");
  addr_width_a: assert property (rd && haddr == 32'h10
    |=> hrdata[29:28] == 2'h0) else $error("width code");
  unmapped_a: assert property (rd && haddr == 32'h1C
    |=> hrdata == 32'h0) else $error("unmapped read");
  data_hold_a: assert property (!rd
    |=> $stable(hrdata)) else $error("read data moved");
  resp_okay_a: assert property (hreadyout && !hresp)
    else $error("not ready or error");
  cover property (rd && haddr == 32'h0);
  cover property (hsel && htrans == 2'h2 && hwrite && haddr == 32'h14);
  cover property (rd && haddr == 32'h18);
endmodule : frm_table_chk
bind frm_table frm_table_chk frm_table_chk_inst (.clock(clock),
  .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp));

// ===== sim/frm_host_model.sv
`timescale 1ns/10ps
module frm_host_model (
  input  wire logic [7:0]  local_addr, // local address
  input  wire logic        byte1_sel,  // byte 1 placement
  input  wire logic        nvol_sel,   // non-volatile base
  input  wire logic [31:0] vol,        // volatile base
  input  wire logic [31:0] nvol,       // non-volatile base
  input  wire logic [1:0]  width,      // address byte code
  output      logic [31:0] addr        // address on the wire
);
  logic [31:0] full;
  // base plus local address, then cut to the advertised width
  always_comb begin
    full = (nvol_sel ? nvol : vol)
      + (byte1_sel ? {16'h0, local_addr, 8'h0} : {24'h0, local_addr});
    case (width)
      2'h0: addr = {24'h0, full[7:0]};
      2'h1: addr = {16'h0, full[15:0]};
      2'h2: addr = {8'h0, full[23:0]};
      default: addr = full;
    endcase
  end
endmodule : frm_host_model

// ===== sim/frm_table_tb_top.sv
`timescale 1ns/10ps
module frm_table_tb_top;
  logic        clock, sys_rst, hwrite, hreadyout, hresp, rd_dp, nv, b1;
  logic [31:0] haddr, hwdata, hrdata, exp_addr;
  logic [1:0]  htrans;
  logic [7:0]  la;
  logic [9:0]  ctrl;
  logic [31:0] exp_q[$];
  int          fail_count, n_tests;
  frm_table frm_table_inst (.clock(clock), .sys_rst(sys_rst),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  frm_host_model frm_host_model_inst (.local_addr(la), .byte1_sel(b1),
    .nvol_sel(nv), .vol(frm_pkg::VOL_BASE_DEF),
    .nvol(frm_pkg::NVOL_BASE_DEF), .width(2'h0), .addr(exp_addr));
  // clock of 100 ns
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // one single transfer; a read notes its expected word
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge clock);
    if (!w) exp_q.push_back(d);
    htrans <= frm_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= a;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp  <= !w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd_dp  <= 1'b0;
  endtask : bus
  task automatic finish_test;
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  // compares read data against the oldest note
  always @(posedge clock) begin
    if (rd_dp === 1'b1 && hreadyout === 1'b1) begin
      n_tests++;
      if (hrdata !== exp_q[0] || hresp !== 1'b0) begin
        fail_count++;
        $display("mismatch at %0t: got %h", $time, hrdata);
      end
      void'(exp_q.pop_front());
    end
  end
  // cuts a hang short
  initial begin
    #500000;
    fail_count++;
    $display("mismatch at %0t: timeout", $time);
    finish_test();
  end
  // main sequence
  initial begin
    sys_rst = 1'b1;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    rd_dp = 1'b0;
    fail_count = 0;
    n_tests = 0;
    ctrl = 10'h0;
    void'($urandom(32'hEEEA));
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    bus(0, 32'h00, {frm_pkg::TABLE_LEN, 24'h010187});
    bus(1, 32'h00, 32'h0);
    bus(0, 32'h00, {frm_pkg::TABLE_LEN, 24'h010187});
    bus(0, 32'h04, {8'hFF, frm_pkg::TABLE_PTR_DEF});
    bus(0, 32'h08, frm_pkg::VOL_BASE_DEF);
    bus(0, 32'h0C, frm_pkg::NVOL_BASE_DEF);
    bus(0, 32'h10, frm_pkg::CMD_WORD_DEF);
    bus(0, 32'h1C, 32'h0);
    bus(0, 32'h100, 32'h0);
    // read back the request, write a new random one, then the formed address
    for (int i = 0; i < 8; i++) begin
      bus(0, 32'h14, {21'h0, ctrl[7:0] == frm_pkg::DIRECT_ADDR,
                      ctrl});
      la = (i == 0) ? frm_pkg::DIRECT_ADDR : 8'($urandom);
      b1 = 1'($urandom);
      nv = 1'($urandom);
      ctrl = {nv, b1, la};
      bus(1, 32'h14, {22'h0, ctrl});
      repeat (2) @(posedge clock);
      bus(0, 32'h18, exp_addr);
    end
    // a write above the map is ignored; a reset clears the request
    bus(1, 32'h114, 32'h3FF);
    bus(0, 32'h14, {21'h0, ctrl[7:0] == frm_pkg::DIRECT_ADDR,
                    ctrl});
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    bus(0, 32'h14, frm_pkg::CALC_CTRL_RST);
    repeat (3) @(posedge clock);
    finish_test();
  end
endmodule : frm_table_tb_top
